// ### verilog/mcsd_decoder.sv
// command decoder, executor and reply builder for one axis
`timescale 1ns/1ps
`default_nettype none
module mcsd_decoder #(
  parameter int AXIS_SETS = 16,
  parameter int MOD_SETS = 16,
  parameter int COORDS = 4,
  parameter int PROG_WORDS = 64,
  parameter int NUM_OUT = 8,
  parameter int NUM_IN = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // incoming command bytes
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  // outgoing reply bytes
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  // program control
  input wire logic download_en,
  input wire logic run_en,
  input wire logic cfg_locked,
  // motion engine side
  output logic [7:0] motion_mode,
  output logic [31:0] motion_value,
  input wire logic pos_reached,
  // general purpose pins
  output logic [NUM_OUT-1:0] dout,
  input wire logic [NUM_IN-1:0] din,
  // status for observation
  output logic busy,
  output logic [31:0] accu,
  output logic cond_zero,
  output logic cond_neg
);
  import mcsd_pkg::*;

  mcsd_state_t state_q;
  logic [7:0] frame_q [FRAME_BYTES];
  logic [3:0] rx_cnt_q;
  logic [3:0] tx_cnt_q;
  logic [7:0] status_q;
  logic [31:0] rval_q;
  logic [31:0] acc_q, x_q;
  logic zero_q, neg_q;
  logic [31:0] axis_q [AXIS_SETS];
  logic [31:0] mod_q [MOD_SETS];
  logic [31:0] uv_nv_q [MOD_SETS];
  logic [31:0] stored_coordinate_target_q [COORDS];
  logic [55:0] prog_q [PROG_WORDS];
  logic [$clog2(PROG_WORDS)-1:0] wr_ptr_q, pc_q;
  logic [31:0] wait_cnt_q;
  logic [7:0] wait_cond_q;
  logic [7:0] mode_q;
  logic [31:0] mval_q;
  logic [31:0] pos_q;
  logic [NUM_OUT-1:0] dout_q;
  logic from_prog_q;

  // decoded fields of the current command
  logic [7:0] c_cmd, c_type, c_bank, sum_d;
  logic [31:0] c_val;
  logic [55:0] pword;
  assign pword = prog_q[pc_q];
  assign c_cmd = from_prog_q ? pword[55:48] : frame_q[1];
  assign c_type = from_prog_q ? pword[47:40] : frame_q[2];
  assign c_bank = from_prog_q ? pword[39:32] : frame_q[3];
  assign c_val = from_prog_q ? pword[31:0] :
    {frame_q[4], frame_q[5], frame_q[6], frame_q[7]};

  // running 8-bit sum over the first eight bytes
  always_comb begin
    sum_d = 8'h00;
    for (int i = 0; i < SUM_IDX; i++) begin
      sum_d = sum_d + frame_q[i];
    end
  end
  logic sum_ok;
  assign sum_ok = (sum_d == frame_q[SUM_IDX]);

  // arithmetic shared by constant and X-register forms
  function automatic logic [31:0] arith(input logic [7:0] op, input logic [31:0] a,
                                        input logic [31:0] b);
    case (op)
      OP_ADD: arith = a + b;
      OP_SUB: arith = a - b;
      OP_AND: arith = a & b;
      OP_OR: arith = a | b;
      OP_XOR: arith = a ^ b;
      OP_NOT: arith = ~a;
      OP_LOAD: arith = b;
      default: arith = a;
    endcase
  endfunction
  logic op_ok;
  assign op_ok = (c_type <= OP_TO_X) && (c_type != 8'h02) && (c_type != 8'h03)
    && (c_type != 8'h04);

  // execution outcome of the current command, decided combinationally
  logic [7:0] st_d;
  logic [31:0] rv_d;
  always_comb begin
    st_d = ST_OK;
    rv_d = c_val;
    if (!from_prog_q && !sum_ok) begin
      st_d = ST_BAD_SUM;
    end else if (!from_prog_q && download_en) begin
      st_d = ST_STORED;
    end else begin
      case (c_cmd)
        CMD_SPIN_CW, CMD_SPIN_CCW, CMD_HALT, CMD_COMPARE, CMD_STOP: st_d = ST_OK;
        CMD_GOTO: if (c_type > TGT_STORED_COORDINATE_TARGET || (c_type == TGT_STORED_COORDINATE_TARGET && c_val >= COORDS))
          st_d = (c_type > TGT_STORED_COORDINATE_TARGET) ? ST_BAD_TYPE : ST_BAD_VALUE;
        CMD_WR_AXIS, CMD_RD_AXIS, CMD_ACC_AXIS: begin
          if (c_type >= AXIS_SETS) st_d = ST_BAD_TYPE;
          else rv_d = axis_q[c_type[$clog2(AXIS_SETS)-1:0]];
        end
        CMD_WR_MOD, CMD_RD_MOD, CMD_ACC_MOD: begin
          if (c_type >= MOD_SETS) st_d = ST_BAD_TYPE;
          else if (c_cmd != CMD_RD_MOD && cfg_locked && c_bank != UV_BANK)
            st_d = ST_LOCKED;
          else rv_d = mod_q[c_type[$clog2(MOD_SETS)-1:0]];
        end
        CMD_SAVE_UV, CMD_LOAD_UV: begin
          if (c_bank != UV_BANK) st_d = ST_BAD_VALUE;
          else if (c_type >= MOD_SETS) st_d = ST_BAD_TYPE;
        end
        CMD_DRIVE_OUT: if (c_type >= NUM_OUT) st_d = ST_BAD_TYPE;
        CMD_SAMPLE_IN: begin
          if (c_type >= NUM_IN) st_d = ST_BAD_TYPE;
          else rv_d = {31'h0, din[c_type[$clog2(NUM_IN)-1:0]]};
        end
        CMD_ARITH_K, CMD_ARITH_X: if (!op_ok) st_d = ST_BAD_TYPE;
        CMD_WAIT: begin
          if (c_type > WAIT_POS) st_d = ST_BAD_TYPE;
          else if (!from_prog_q) st_d = ST_UNAVAIL; // only inside a program
        end
        8'h0d, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1e, 8'h1f, 8'h20,
        8'h24, 8'h25, 8'h26, 8'h27: st_d = ST_UNAVAIL; // known but not built here
        default: st_d = ST_BAD_CMD;
      endcase
    end
  end
  logic exec_ok;
  assign exec_ok = (st_d == ST_OK);

  // control sequence: receive, execute, reply or step program
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= MCSD_IDLE;
      rx_cnt_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      from_prog_q <= 1'b0;
      status_q <= ST_OK;
      rval_q <= 32'h0;
      pc_q <= '0;
      wr_ptr_q <= '0;
      wait_cnt_q <= 32'h0;
      wait_cond_q <= WAIT_TICKS;
    end else begin
      case (state_q)
        MCSD_IDLE: begin
          rx_cnt_q <= 4'h0;
          if (rx_valid) begin
            state_q <= MCSD_RECV; // host frames win over program steps
          end else if (run_en && !download_en) begin
            from_prog_q <= 1'b1;
            state_q <= MCSD_EXEC;
          end
          if (!run_en) pc_q <= '0;
          if (!download_en) wr_ptr_q <= '0;
        end
        MCSD_RECV: begin
          if (rx_valid && rx_cnt_q == 4'(FRAME_BYTES - 2)) begin
            from_prog_q <= 1'b0;
            state_q <= MCSD_EXEC;
          end
          if (rx_valid) rx_cnt_q <= rx_cnt_q + 4'h1;
        end
        MCSD_EXEC: begin
          if (from_prog_q) begin
            from_prog_q <= 1'b0;
            state_q <= MCSD_IDLE;
            pc_q <= pc_q + 1'b1;
            if (c_cmd == CMD_STOP) begin
              pc_q <= pc_q;
            end else if (c_cmd == CMD_WAIT && exec_ok) begin
              wait_cnt_q <= c_val;
              wait_cond_q <= c_type;
              state_q <= MCSD_WAIT;
            end
          end else begin
            status_q <= st_d;
            rval_q <= rv_d;
            tx_cnt_q <= 4'h0;
            state_q <= MCSD_SEND;
            if (st_d == ST_STORED) wr_ptr_q <= wr_ptr_q + 1'b1;
          end
        end
        MCSD_SEND: begin
          if (tx_ready) begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == 4'(SUM_IDX)) state_q <= run_en ? MCSD_WAIT : MCSD_IDLE;
          end
        end
        MCSD_WAIT: begin
          if (rx_valid) begin
            state_q <= MCSD_RECV; // host served while the program sleeps
          end else if ((wait_cond_q == WAIT_POS && pos_reached) || wait_cnt_q == 32'h0) begin
            state_q <= MCSD_IDLE;
          end
          if (wait_cnt_q != 32'h0) wait_cnt_q <= wait_cnt_q - 32'h1;
        end
        default: state_q <= MCSD_IDLE;
      endcase
    end
  end

  // capture frame bytes, address byte first
  always_ff @(posedge mclk) begin
    if ((state_q == MCSD_IDLE || state_q == MCSD_WAIT) && rx_valid) begin
      frame_q[0] <= rx_byte;
    end else if (state_q == MCSD_RECV && rx_valid) begin
      frame_q[rx_cnt_q + 4'h1] <= rx_byte;
    end
  end

  // program store written by download frames
  always_ff @(posedge mclk) begin
    if (state_q == MCSD_EXEC && !from_prog_q && st_d == ST_STORED) begin
      prog_q[wr_ptr_q] <= {c_cmd, c_type, c_bank, c_val};
    end
  end

  // axis settings, module settings and user-variable store
  always_ff @(posedge mclk) begin
    if (state_q == MCSD_EXEC && exec_ok) begin
      case (c_cmd)
        CMD_WR_AXIS: axis_q[c_type[$clog2(AXIS_SETS)-1:0]] <= c_val;
        CMD_ACC_AXIS: axis_q[c_type[$clog2(AXIS_SETS)-1:0]] <= acc_q;
        CMD_WR_MOD: mod_q[c_type[$clog2(MOD_SETS)-1:0]] <= c_val;
        CMD_ACC_MOD: mod_q[c_type[$clog2(MOD_SETS)-1:0]] <= acc_q;
        CMD_SAVE_UV: uv_nv_q[c_type[$clog2(MOD_SETS)-1:0]] <=
          mod_q[c_type[$clog2(MOD_SETS)-1:0]];
        CMD_LOAD_UV: mod_q[c_type[$clog2(MOD_SETS)-1:0]] <=
          uv_nv_q[c_type[$clog2(MOD_SETS)-1:0]];
        default: ;
      endcase
    end
  end

  // accumulator, X register and flags
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      acc_q <= 32'h0;
      x_q <= 32'h0;
      zero_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (state_q == MCSD_EXEC && exec_ok) begin
      if (c_cmd == CMD_ARITH_K || c_cmd == CMD_ARITH_X) begin
        if (c_type == OP_TO_X) x_q <= acc_q;
        else acc_q <= arith(c_type, acc_q, c_cmd == CMD_ARITH_K ? c_val : x_q);
      end else if (c_cmd == CMD_COMPARE) begin
        zero_q <= (acc_q == c_val);
        neg_q <= ($signed(acc_q) < $signed(c_val));
      end else if (from_prog_q && (c_cmd == CMD_RD_AXIS || c_cmd == CMD_RD_MOD
                   || c_cmd == CMD_SAMPLE_IN)) begin
        acc_q <= rv_d; // host reads skip this
      end
    end
  end

  // motion request and outputs
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mode_q <= MOTION_STOP;
      mval_q <= 32'h0;
      pos_q <= 32'h0;
      dout_q <= '0;
    end else if (state_q == MCSD_EXEC && exec_ok) begin
      case (c_cmd)
        CMD_SPIN_CW: begin mode_q <= MOTION_CW; mval_q <= c_val; end
        CMD_SPIN_CCW: begin mode_q <= MOTION_CCW; mval_q <= c_val; end
        CMD_HALT: mode_q <= MOTION_STOP;
        CMD_GOTO: begin
          mode_q <= MOTION_GOTO;
          case (c_type)
            TGT_ABS: begin mval_q <= c_val; pos_q <= c_val; end
            TGT_REL: begin mval_q <= pos_q + c_val; pos_q <= pos_q + c_val; end
            default: begin
              mval_q <= stored_coordinate_target_q[c_val[$clog2(COORDS)-1:0]];
              pos_q <= stored_coordinate_target_q[c_val[$clog2(COORDS)-1:0]];
            end
          endcase
        end
        CMD_DRIVE_OUT: dout_q[c_type[$clog2(NUM_OUT)-1:0]] <= c_val[0];
        default: ;
      endcase
    end
  end

  // coordinates start cleared
  for (genvar g = 0; g < COORDS; g++) begin : g_stored_coordinate_target
    always_ff @(posedge mclk) begin
      if (!resetn) stored_coordinate_target_q[g] <= 32'h0;
    end
  end

  // reply bytes; checksum over the eight before it
  logic [7:0] reply [FRAME_BYTES];
  logic [7:0] rsum;
  always_comb begin
    reply[0] = REPLY_ADDR_RST;
    reply[1] = MODULE_ADDR_RST;
    reply[2] = status_q;
    reply[3] = frame_q[1];
    reply[4] = rval_q[31:24];
    reply[5] = rval_q[23:16];
    reply[6] = rval_q[15:8];
    reply[7] = rval_q[7:0];
    rsum = 8'h00;
    for (int i = 0; i < SUM_IDX; i++) rsum = rsum + reply[i];
    reply[SUM_IDX] = rsum;
  end
  assign tx_valid = (state_q == MCSD_SEND);
  assign tx_byte = reply[tx_cnt_q];
  assign motion_mode = mode_q;
  assign motion_value = mval_q;
  assign dout = dout_q;
  assign busy = (state_q != MCSD_IDLE);
  assign accu = acc_q;
  assign cond_zero = zero_q;
  assign cond_neg = neg_q;

  // checks
  a_bad_sum_status: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == MCSD_EXEC && !from_prog_q && !sum_ok) |=> status_q == ST_BAD_SUM)
    else $error("bad checksum not reported");
  a_host_read_acc: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == MCSD_EXEC && !from_prog_q && c_cmd == CMD_RD_AXIS) |=> $stable(acc_q))
    else $error("host read changed accumulator");
  a_reply_len: assert property (@(posedge mclk) disable iff (!resetn)
    (tx_valid && tx_ready && tx_cnt_q == 4'(SUM_IDX)) |=> !tx_valid)
    else $error("reply length wrong");
  // a host frame that finished executing must open its reply at byte zero
  sequence s_host_exec;
    state_q == MCSD_EXEC && !from_prog_q;
  endsequence
  sequence s_reply_open;
    tx_valid && tx_cnt_q == 4'h0;
  endsequence
  a_reply_opens: assert property (@(posedge mclk) disable iff (!resetn)
    s_host_exec |=> s_reply_open)
    else $error("reply did not start after execution");
  a_stored_status: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == MCSD_EXEC && !from_prog_q && sum_ok && download_en) |=> status_q == ST_STORED)
    else $error("download frame not reported as stored");
  a_bad_sum_hold: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == MCSD_EXEC && !from_prog_q && !sum_ok) |=> $stable(motion_mode))
    else $error("bad frame changed motion");
  a_spin_mode: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == MCSD_EXEC && exec_ok && c_cmd == CMD_SPIN_CW) |=> motion_mode == MOTION_CW)
    else $error("spin right not applied");
endmodule
`default_nettype wire

// ### verilog/mcsd_pkg.sv
// constants and shared types of the motion command decoder
// Function
// - every reply carries a one-byte status code telling how the command went
// - a command that executes cleanly reports status 100
// - a command stored into program memory instead of run reports 101
// - errors: 1 checksum, 2 unknown, 3 type, 4 value, 5 locked, 6 unavailable
// - command 1 spins the motor right at value velocity, 2 spins left
// - command 4 moves to absolute, relative or stored-coordinate target
// - command 5 writes an axis setting by type, 6 reads it back
// - command 9 writes a module setting by type (bank only decides the lock), 10 reads it
// - commands 11 and 12 save and reload user variables only
// - command 14 drives the chosen digital output to the value
// - command 15 returns the chosen input state in the reply value
// - command 19 does type-selected arithmetic of accumulator and value
// - command 33 does type-selected arithmetic of accumulator and X register
// - command 20 compares accumulator with value and sets condition flags
// - command 34 copies accumulator to axis setting, 35 to module setting
// - command 27 suspends the program until condition or tick timeout
// - a downloaded program is stored and later runs without the host
// - a command frame is nine bytes, value most significant byte first
// - checksum is the 8-bit sum of all preceding bytes, both directions
// - reply holds reply address, module address, status, command, value, sum
package mcsd_pkg;
  localparam int FRAME_BYTES = 9;
  localparam int SUM_IDX = 8;
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_STORED = 8'h65;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] ST_LOCKED = 8'h05;
  localparam logic [7:0] ST_UNAVAIL = 8'h06;
  localparam logic [7:0] CMD_SPIN_CW = 8'h01;
  localparam logic [7:0] CMD_SPIN_CCW = 8'h02;
  localparam logic [7:0] CMD_HALT = 8'h03;
  localparam logic [7:0] CMD_GOTO = 8'h04;
  localparam logic [7:0] CMD_WR_AXIS = 8'h05;
  localparam logic [7:0] CMD_RD_AXIS = 8'h06;
  localparam logic [7:0] CMD_WR_MOD = 8'h09;
  localparam logic [7:0] CMD_RD_MOD = 8'h0a;
  localparam logic [7:0] CMD_SAVE_UV = 8'h0b;
  localparam logic [7:0] CMD_LOAD_UV = 8'h0c;
  localparam logic [7:0] CMD_DRIVE_OUT = 8'h0e;
  localparam logic [7:0] CMD_SAMPLE_IN = 8'h0f;
  localparam logic [7:0] CMD_ARITH_K = 8'h13;
  localparam logic [7:0] CMD_COMPARE = 8'h14;
  localparam logic [7:0] CMD_WAIT = 8'h1b;
  localparam logic [7:0] CMD_STOP = 8'h1c;
  localparam logic [7:0] CMD_ARITH_X = 8'h21;
  localparam logic [7:0] CMD_ACC_AXIS = 8'h22;
  localparam logic [7:0] CMD_ACC_MOD = 8'h23;
  localparam logic [7:0] TGT_ABS = 8'h00;
  localparam logic [7:0] TGT_REL = 8'h01;
  localparam logic [7:0] TGT_STORED_COORDINATE_TARGET = 8'h02;
  localparam logic [7:0] OP_ADD = 8'h00;
  localparam logic [7:0] OP_SUB = 8'h01;
  localparam logic [7:0] OP_AND = 8'h05;
  localparam logic [7:0] OP_OR = 8'h06;
  localparam logic [7:0] OP_XOR = 8'h07;
  localparam logic [7:0] OP_NOT = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;
  localparam logic [7:0] OP_TO_X = 8'h0a;
  localparam logic [7:0] WAIT_TICKS = 8'h00;
  localparam logic [7:0] WAIT_POS = 8'h01;
  localparam logic [7:0] UV_BANK = 8'h02;
  localparam logic [7:0] MOTION_STOP = 8'h00;
  localparam logic [7:0] MOTION_CW = 8'h01;
  localparam logic [7:0] MOTION_CCW = 8'h02;
  localparam logic [7:0] MOTION_GOTO = 8'h03;
  localparam logic [7:0] REPLY_ADDR_RST = 8'h02;
  localparam logic [7:0] MODULE_ADDR_RST = 8'h01;
  typedef enum logic [4:0] {
    MCSD_IDLE = 5'b00001,
    MCSD_RECV = 5'b00010,
    MCSD_EXEC = 5'b00100,
    MCSD_SEND = 5'b01000,
    MCSD_WAIT = 5'b10000
  } mcsd_state_t;
endpackage

// ### test/mcsd_host_model.sv
// host-side model that frames commands and collects replies
`timescale 1ns/1ps
`default_nettype none
module mcsd_host_model
  import mcsd_pkg::*;
(
  // clock
  input wire logic mclk,
  // command bytes toward the decoder
  output var logic [7:0] rx_byte,
  output var logic rx_valid,
  // reply bytes from the decoder
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output var logic tx_ready
);
  import mcsd_pkg::*;
  logic [7:0] rsp [9];
  logic lost;

  // idle lines at time zero
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    lost = 1'b0;
  end

  // one whole exchange; a slow host stalls two cycles before each reply byte
  task automatic exchange(input logic [7:0] cmd, input logic [7:0] typ,
      input logic [7:0] bank, input logic [31:0] val, input bit bad, input bit slow);
    logic [7:0] f [9];
    int k;
    int n;
    f[0] = MODULE_ADDR_RST;
    f[1] = cmd;
    f[2] = typ;
    f[3] = bank;
    {f[4], f[5], f[6], f[7]} = val;
    f[8] = 8'h00;
    for (k = 0; k < 8; k++) f[8] = f[8] + f[k];
    if (bad) f[8] = ~f[8];
    for (k = 0; k < 9; k++) begin
      @(posedge mclk);
      #1;
      rx_byte = f[k];
      rx_valid = 1'b1;
    end
    @(posedge mclk);
    #1;
    rx_valid = 1'b0;
    rx_byte = ~f[8]; // no stale byte left on an idle line
    lost = 1'b0;
    // the reply is fully taken before the caller may send again
    for (k = 0; k < 9 && !lost; k++) begin
      if (slow) begin
        tx_ready = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
      end
      tx_ready = 1'b1;
      n = 0;
      while (tx_valid !== 1'b1 && n < 60) begin
        @(posedge mclk);
        #1;
        n++;
      end
      if (n >= 60) lost = 1'b1;
      rsp[k] = tx_byte;
      @(posedge mclk);
      #1;
    end
    tx_ready = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/motion_command_status_decoder_tb.sv
// self-checking bench for the motion command decoder
`timescale 1ns/1ps
`default_nettype none
module motion_command_status_decoder_tb;
  import mcsd_pkg::*;
  logic mclk;
  logic resetn;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] tx_byte;
  logic tx_valid;
  logic tx_ready;
  logic download_en;
  logic run_en;
  logic cfg_locked;
  logic [7:0] motion_mode;
  logic [31:0] motion_value;
  logic [7:0] dout;
  logic [7:0] din;
  logic busy;
  logic [31:0] accu;
  logic cond_zero;
  logic cond_neg;
  logic [31:0] rval;
  int err_total;
  int check_count;

  // position feedback is tied off; the stored program's position wait ends on its zero tick count, then the program stops
  mcsd_decoder dut_u (.mclk(mclk), .resetn(resetn), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .download_en(download_en),
    .run_en(run_en), .cfg_locked(cfg_locked), .motion_mode(motion_mode),
    .motion_value(motion_value), .pos_reached(1'b0), .dout(dout), .din(din), .busy(busy),
    .accu(accu), .cond_zero(cond_zero), .cond_neg(cond_neg));

  mcsd_host_model host_u (.mclk(mclk), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // counted comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one exchange plus the framing checks every reply must pass
  task automatic run(input logic [7:0] cmd, input logic [7:0] typ, input logic [7:0] bank,
      input logic [31:0] val, input logic [7:0] st, input bit bad = 0, input bit slow = 0);
    logic [7:0] sum;
    int k;
    host_u.exchange(cmd, typ, bank, val, bad, slow);
    if (host_u.lost) begin
      err_total++;
      $display("wrong value at %0t: reply never came", $time);
      test_done();
    end
    sum = 8'h00;
    for (k = 0; k < 8; k++) sum = sum + host_u.rsp[k];
    check(host_u.rsp[0], REPLY_ADDR_RST, "reply address");
    check(host_u.rsp[1], MODULE_ADDR_RST, "module address");
    check(host_u.rsp[2], st, "status");
    check(host_u.rsp[3], cmd, "echoed command");
    check(host_u.rsp[8], sum, "reply checksum");
    rval = {host_u.rsp[4], host_u.rsp[5], host_u.rsp[6], host_u.rsp[7]};
  endtask

  // state straight after reset
  task automatic test_reset();
    check(motion_mode, MOTION_STOP, "mode after reset");
    check(tx_valid, 1'b0, "tx idle after reset");
    check(busy, 1'b0, "idle after reset");
    check(dout, 8'h00, "outputs after reset");
    $display("test reset done");
  endtask

  // spin both ways, goto with all target kinds, halt
  task automatic test_motion();
    run(CMD_SPIN_CW, 8'h00, 8'h00, 32'h0000_03e8, ST_OK);
    check(motion_mode, MOTION_CW, "spin right");
    check(motion_value, 32'h0000_03e8, "spin right speed");
    run(CMD_SPIN_CCW, 8'h00, 8'h00, 32'h0000_0200, ST_OK, 0, 1);
    check(motion_mode, MOTION_CCW, "spin left");
    run(CMD_GOTO, TGT_ABS, 8'h00, 32'hfff8_3000, ST_OK);
    check(motion_mode, MOTION_GOTO, "goto mode");
    check(motion_value, 32'hfff8_3000, "goto target");
    run(CMD_GOTO, TGT_REL, 8'h00, 32'h0000_0010, ST_OK);
    run(CMD_GOTO, TGT_STORED_COORDINATE_TARGET, 8'h00, 32'h0000_0001, ST_OK);
    check(motion_mode, MOTION_GOTO, "goto stored");
    run(CMD_HALT, 8'h00, 8'h00, 32'h0, ST_OK);
    check(motion_mode, MOTION_STOP, "halt");
    $display("test motion done");
  endtask

  // axis and module settings, locked memory, user variables
  task automatic test_params();
    run(CMD_WR_AXIS, 8'h03, 8'h00, 32'h1234_5678, ST_OK);
    run(CMD_RD_AXIS, 8'h03, 8'h00, 32'h0, ST_OK);
    check(rval, 32'h1234_5678, "axis read back");
    run(CMD_WR_MOD, 8'h04, 8'h00, 32'h0000_a5a5, ST_OK);
    run(CMD_RD_MOD, 8'h04, 8'h00, 32'h0, ST_OK);
    check(rval, 32'h0000_a5a5, "module read back");
    #1;
    cfg_locked = 1'b1;
    run(CMD_WR_MOD, 8'h04, 8'h00, 32'h1, ST_LOCKED);
    run(CMD_WR_MOD, 8'h01, UV_BANK, 32'h0000_0042, ST_OK);
    cfg_locked = 1'b0;
    run(CMD_SAVE_UV, 8'h01, UV_BANK, 32'h0, ST_OK);
    run(CMD_WR_MOD, 8'h01, UV_BANK, 32'h0000_0099, ST_OK);
    run(CMD_LOAD_UV, 8'h01, UV_BANK, 32'h0, ST_OK);
    run(CMD_RD_MOD, 8'h01, UV_BANK, 32'h0, ST_OK);
    check(rval, 32'h0000_0042, "user variable kept");
    $display("test params done");
  endtask

  // digital output and input sampling
  task automatic test_io();
    run(CMD_DRIVE_OUT, 8'h02, 8'h00, 32'h1, ST_OK);
    check(dout, 8'h04, "output set");
    din = 8'h20;
    run(CMD_SAMPLE_IN, 8'h05, 8'h00, 32'h0, ST_OK);
    check(rval, 32'h1, "input high");
    run(CMD_SAMPLE_IN, 8'h04, 8'h00, 32'h0, ST_OK);
    check(rval, 32'h0, "input low");
    $display("test io done");
  endtask

  // accumulator arithmetic, compare, copies, reads leave accu alone
  task automatic test_arith();
    run(CMD_ARITH_K, OP_LOAD, 8'h00, 32'h0000_0010, ST_OK);
    run(CMD_ARITH_K, OP_ADD, 8'h00, 32'h0000_0005, ST_OK);
    check(accu, 32'h0000_0015, "accu add");
    run(CMD_COMPARE, 8'h00, 8'h00, 32'h0000_0015, ST_OK);
    check({cond_zero, cond_neg}, 2'b10, "equal flags");
    run(CMD_ARITH_K, OP_TO_X, 8'h00, 32'h0, ST_OK);
    run(CMD_ARITH_X, OP_ADD, 8'h00, 32'h0, ST_OK);
    check(accu, 32'h0000_002a, "accu plus x");
    run(CMD_COMPARE, 8'h00, 8'h00, 32'h0000_0100, ST_OK);
    check({cond_zero, cond_neg}, 2'b01, "less flags");
    run(CMD_ARITH_K, 8'h02, 8'h00, 32'h1, ST_BAD_TYPE);
    run(CMD_ACC_AXIS, 8'h03, 8'h00, 32'h0, ST_OK);
    run(CMD_RD_AXIS, 8'h03, 8'h00, 32'h0, ST_OK);
    check(rval, 32'h0000_002a, "accu to axis");
    check(accu, 32'h0000_002a, "read keeps accu");
    run(CMD_ACC_MOD, 8'h04, 8'h00, 32'h0, ST_OK);
    run(CMD_RD_MOD, 8'h04, 8'h00, 32'h0, ST_OK);
    check(rval, 32'h0000_002a, "accu to module");
    $display("test arith done");
  endtask

  // bad checksum, unknown and unavailable commands, program download
  task automatic test_errors();
    run(CMD_SPIN_CW, 8'h00, 8'h00, 32'h0000_0777, ST_BAD_SUM, 1);
    check(motion_mode, MOTION_STOP, "bad frame not run");
    run(8'h07, 8'h00, 8'h00, 32'h0, ST_BAD_CMD);
    run(8'h0d, 8'h00, 8'h00, 32'h0, ST_UNAVAIL);
    run(CMD_WAIT, WAIT_TICKS, 8'h00, 32'h5, ST_UNAVAIL);
    #1;
    download_en = 1'b1;
    run(CMD_SPIN_CW, 8'h00, 8'h00, 32'h0000_0100, ST_STORED);
    run(CMD_WAIT, WAIT_POS, 8'h00, 32'h0, ST_STORED);
    run(CMD_STOP, 8'h00, 8'h00, 32'h0, ST_STORED);
    check(motion_mode, MOTION_STOP, "stored not run");
    download_en = 1'b0;
    $display("test errors done");
  endtask

  // the downloaded program runs by itself with no host frames
  task automatic test_program();
    run_en = 1'b1;
    repeat (20) @(posedge mclk);
    #1;
    check(motion_mode, MOTION_CW, "program spin");
    check(motion_value, 32'h0000_0100, "program speed");
    run_en = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    $display("test program done");
  endtask

  // reset for 12 cycles, then the scenarios
  initial begin
    resetn = 1'b0;
    download_en = 1'b0;
    run_en = 1'b0;
    cfg_locked = 1'b0;
    din = 8'h00;
    err_total = 0;
    check_count = 0;
    repeat (12) @(posedge mclk);
    #1;
    resetn = 1'b1;
    test_reset();
    test_motion();
    test_params();
    test_io();
    test_arith();
    test_errors();
    test_program();
    test_done();
  end
endmodule
`default_nettype wire
